/* File: src/core_exec_pkg.sv */
// package of constants for the increment and branch execution block
// assumes one clock domain and a classic wishbone register bus
package core_exec_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_INC_A    = 8'h04;
    localparam logic [7:0] OP_INC_DIR  = 8'h05;
    localparam logic [7:0] OP_INC_IND0 = 8'h06;
    localparam logic [7:0] OP_INC_IND1 = 8'h07;
    localparam logic [4:0] OP_INC_REG  = 5'h01;
    localparam logic [7:0] OP_INC_DATA_POINTER = 8'hA3;
    localparam logic [7:0] OP_JBC      = 8'h10;
    localparam logic [7:0] OP_JB       = 8'h20;
    localparam logic [7:0] OP_JNB      = 8'h30;
    localparam logic [7:0] OP_JC       = 8'h40;
    localparam logic [7:0] OP_JMP_IND  = 8'h73;

    // ----------------------------------------------------------------
    // direct address space
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT   = 8'h80;
    localparam logic [7:0] ADDR_DPL    = 8'h82;
    localparam logic [7:0] ADDR_DPH    = 8'h83;
    localparam logic [7:0] ADDR_PSW    = 8'hD0;
    localparam logic [7:0] ADDR_ACC    = 8'hE0;
    localparam logic [3:0] BIT_AREA_HI = 4'h2;
    localparam int         CARRY_BIT   = 7;

    // ----------------------------------------------------------------
    // instruction lengths
    // ----------------------------------------------------------------
    localparam logic [1:0] LEN_ONE   = 2'd1;
    localparam logic [1:0] LEN_TWO   = 2'd2;
    localparam logic [1:0] LEN_THREE = 2'd3;

    // ----------------------------------------------------------------
    // register word indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL     = 4'h0;
    localparam logic [3:0] IDX_STATUS   = 4'h1;
    localparam logic [3:0] IDX_INSTR    = 4'h2;
    localparam logic [3:0] IDX_ACC      = 4'h3;
    localparam logic [3:0] IDX_PSW      = 4'h4;
    localparam logic [3:0] IDX_DATA_POINTER     = 4'h5;
    localparam logic [3:0] IDX_PC       = 4'h6;
    localparam logic [3:0] IDX_PORT     = 4'h7;
    localparam logic [3:0] IDX_PINS     = 4'h8;
    localparam logic [3:0] IDX_RAM_ADDR = 4'h9;
    localparam logic [3:0] IDX_RAM_DATA = 4'hA;

    localparam int STAT_BUSY    = 0;
    localparam int STAT_TAKEN   = 1;
    localparam int STAT_ILLEGAL = 2;
    localparam int CTRL_GO      = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [7:0]  PSW_RST   = 8'h00;
    localparam logic [15:0] DATA_POINTER_RST  = 16'h0000;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  PORT_RST  = 8'hFF;
    localparam logic [23:0] INSTR_RST = 24'h00_0000;

endpackage : core_exec_pkg

/* File: src/pc_unit_if.sv */
// carrier between the execution core and its address arithmetic unit
// assumes both ends sit on the same clock
interface pc_unit_if;
    logic [15:0] pc;
    logic [1:0]  len;
    logic [7:0]  rel;
    logic        taken;
    logic        jump;
    logic [7:0]  acc;
    logic [15:0] data_pointer;
    logic [15:0] next_pc;
    logic [15:0] data_pointer_inc;

    modport core (output pc, len, rel, taken, jump, acc, data_pointer, input next_pc, data_pointer_inc);
    modport unit (input pc, len, rel, taken, jump, acc, data_pointer, output next_pc, data_pointer_inc);
endinterface : pc_unit_if

/* File: src/pc_unit.sv */
// sixteen bit address arithmetic for branches, jumps and pointer step
// assumes purely combinational use by the execution core
module pc_unit (
    pc_unit_if.unit u
);
    logic [15:0] disp;
    logic [15:0] advanced;

    // ----------------------------------------------------------------
    // target arithmetic
    // ----------------------------------------------------------------
    always_comb begin
        disp     = {{8{u.rel[7]}}, u.rel};
        advanced = u.pc + {14'h0000, u.len};
        if (u.jump) begin
            u.next_pc = u.data_pointer + {8'h00, u.acc};
        end else if (u.taken) begin
            u.next_pc = advanced + disp;
        end else begin
            u.next_pc = advanced;
        end
        u.data_pointer_inc = u.data_pointer + 16'h0001;
    end
endmodule : pc_unit

/* File: src/inc_branch_exec.sv */
// execution of byte increment, pointer increment, bit and carry branches
// assumes a classic wishbone master and one 40 MHz clock
//
// Behaviour
// - byte increment wraps, flags untouched
// - accumulator, register, direct, indirect operand forms
// - port increment reads output latch
// - pointer increment sixteen bit, no flags
// - bit set branch: advance three, branch
// - set-and-clear branch clears set bit only
// - set-and-clear tests port latch, not pins
// - carry branch: advance two, branch
// - indirect jump: pointer plus accumulator
// - bit clear branch: advance three, branch
//
// Chosen here: the Wishbone slave port and the register offsets.
module inc_branch_exec
    import core_exec_pkg::*;
#(
    parameter int ADR_W    = 6,
    parameter int RAM_ADRW = 7
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [7:0]        port_pins_in,
    output logic      [7:0]        port_out
);
    typedef enum logic {st_idle, st_exec} state_type;
    state_type   state_reg;
    logic [7:0]  ram [2**RAM_ADRW];
    logic [23:0] instr_reg;
    logic [7:0]  acc_reg, psw_reg;
    logic [15:0] data_pointer_reg, pc_reg;
    logic [RAM_ADRW-1:0] ram_addr_reg;
    logic        taken_reg, illegal_reg;
    logic [7:0]  pins_meta, pins_sync;
    logic        bus_req, bus_wr;
    logic [3:0]  idx;
    logic        exec, go;
    logic [7:0]  opcode, b1, b2;
    logic [7:0]  byte_addr, rel, cur_byte, new_byte;
    logic        use_latch, inc_byte, bit_op, data_pointer_op, jump_op, is_jc;
    logic        clr_on_set, test_for, illegal, bit_val, taken, byte_wr;
    logic [1:0]  op_len;
    logic [31:0] rd_data;
    pc_unit_if pcu ();
    pc_unit u_pc_unit (
        .u (pcu)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic en);
        merge8 = en ? new_v : old_v;
    endfunction : merge8

    function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_adr);
        if (bit_adr[7]) begin
            bit_byte_addr = {bit_adr[7:3], 3'b000};
        end else begin
            bit_byte_addr = {BIT_AREA_HI, bit_adr[6:3]};
        end
    endfunction : bit_byte_addr

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins_meta <= 8'h00;
            pins_sync <= 8'h00;
        end else begin
            pins_meta <= port_pins_in;
            pins_sync <= pins_meta;
        end
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && (state_reg == st_idle);
    assign bus_wr  = bus_req && wb_we_i;
    assign idx     = wb_adr_i[ADR_W-1:2];
    assign go      = bus_wr && (idx == IDX_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_GO];
    assign exec    = (state_reg == st_exec);

    always_comb begin
        rd_data = 32'h0000_0000;
        case (idx)
            IDX_STATUS:   rd_data = {29'h0000_0000, illegal_reg, taken_reg, exec};
            IDX_INSTR:    rd_data = {8'h00, instr_reg};
            IDX_ACC:      rd_data = {24'h00_0000, acc_reg};
            IDX_PSW:      rd_data = {24'h00_0000, psw_reg};
            IDX_DATA_POINTER:     rd_data = {16'h0000, data_pointer_reg};
            IDX_PC:       rd_data = {16'h0000, pc_reg};
            IDX_PORT:     rd_data = {24'h00_0000, port_out};
            IDX_PINS:     rd_data = {24'h00_0000, pins_sync};
            IDX_RAM_ADDR: rd_data = {{(32-RAM_ADRW){1'b0}}, ram_addr_reg};
            IDX_RAM_DATA: rd_data = {24'h00_0000, ram[ram_addr_reg]};
            default:      rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= st_idle;
        end else begin
            case (state_reg)
                st_idle: if (go) begin
                    state_reg <= st_exec;
                end
                st_exec: state_reg <= st_idle;
                default: state_reg <= st_idle;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign opcode = instr_reg[7:0];
    assign b1     = instr_reg[15:8];
    assign b2     = instr_reg[23:16];
    always_comb begin
        byte_addr  = ADDR_ACC;
        use_latch  = 1'b1;
        inc_byte   = 1'b0;
        bit_op     = 1'b0;
        data_pointer_op    = 1'b0;
        jump_op    = 1'b0;
        is_jc      = 1'b0;
        clr_on_set = 1'b0;
        test_for   = 1'b1;
        illegal    = 1'b0;
        op_len     = LEN_ONE;
        rel        = b2;
        case (opcode)
            OP_INC_A: inc_byte = 1'b1;
            OP_INC_DIR: begin
                inc_byte  = 1'b1;
                byte_addr = b1;
                op_len    = LEN_TWO;
            end
            OP_INC_IND0, OP_INC_IND1: begin
                inc_byte  = 1'b1;
                byte_addr = {1'b0, ram[{{(RAM_ADRW-1){1'b0}}, opcode[0]}][6:0]};
            end
            OP_INC_DATA_POINTER: data_pointer_op = 1'b1;
            OP_JB: begin
                bit_op    = 1'b1;
                use_latch = 1'b0;
                op_len    = LEN_THREE;
            end
            OP_JNB: begin
                bit_op    = 1'b1;
                use_latch = 1'b0;
                test_for  = 1'b0;
                op_len    = LEN_THREE;
            end
            OP_JBC: begin
                bit_op     = 1'b1;
                clr_on_set = 1'b1;
                op_len     = LEN_THREE;
            end
            OP_JC: begin
                is_jc  = 1'b1;
                op_len = LEN_TWO;
                rel    = b1;
            end
            OP_JMP_IND: jump_op = 1'b1;
            default: begin
                if (opcode[7:3] == OP_INC_REG) begin
                    inc_byte  = 1'b1;
                    byte_addr = {5'b00000, opcode[2:0]};
                end else begin
                    illegal = 1'b1;
                end
            end
        endcase
        if (bit_op) begin
            byte_addr = bit_byte_addr(b1);
        end
    end

    // ----------------------------------------------------------------
    // operand fetch and result
    // ----------------------------------------------------------------
    always_comb begin
        cur_byte = 8'h00;
        if (!byte_addr[7]) begin
            cur_byte = ram[byte_addr[RAM_ADRW-1:0]];
        end else begin
            case (byte_addr)
                ADDR_ACC:  cur_byte = acc_reg;
                ADDR_PSW:  cur_byte = psw_reg;
                ADDR_DPL:  cur_byte = data_pointer_reg[7:0];
                ADDR_DPH:  cur_byte = data_pointer_reg[15:8];
                ADDR_PORT: cur_byte = use_latch ? port_out : pins_sync;
                default:   cur_byte = 8'h00;
            endcase
        end
    end

    assign bit_val  = cur_byte[b1[2:0]];
    assign taken    = bit_op ? (bit_val == test_for) : (is_jc && psw_reg[CARRY_BIT]);
    assign new_byte = bit_op ? (cur_byte & ~(8'h01 << b1[2:0]))
                             : (cur_byte + 8'h01);
    assign byte_wr  = exec && !illegal && (inc_byte || (clr_on_set && bit_val));
    assign pcu.pc    = pc_reg;
    assign pcu.len   = op_len;
    assign pcu.rel   = rel;
    assign pcu.taken = taken;
    assign pcu.jump  = jump_op;
    assign pcu.acc   = acc_reg;
    assign pcu.data_pointer  = data_pointer_reg;
    // ----------------------------------------------------------------
    // architectural state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (byte_wr && !byte_addr[7]) begin
            ram[byte_addr[RAM_ADRW-1:0]] <= new_byte;
        end else if (bus_wr && idx == IDX_RAM_DATA && wb_sel_i[0]) begin
            ram[ram_addr_reg] <= wb_dat_i[7:0];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            instr_reg    <= INSTR_RST;
            ram_addr_reg <= '0;
        end else if (bus_wr) begin
            if (idx == IDX_INSTR) begin
                instr_reg <= {merge8(instr_reg[23:16], wb_dat_i[23:16], wb_sel_i[2]),
                              merge8(instr_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                              merge8(instr_reg[7:0], wb_dat_i[7:0], wb_sel_i[0])};
            end
            if (idx == IDX_RAM_ADDR && wb_sel_i[0]) begin
                ram_addr_reg <= wb_dat_i[RAM_ADRW-1:0];
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_reg <= ACC_RST;
        end else if (byte_wr && byte_addr == ADDR_ACC) begin
            acc_reg <= new_byte;
        end else if (bus_wr && idx == IDX_ACC) begin
            acc_reg <= merge8(acc_reg, wb_dat_i[7:0], wb_sel_i[0]);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            psw_reg <= PSW_RST;
        end else if (byte_wr && byte_addr == ADDR_PSW) begin
            psw_reg <= new_byte;
        end else if (bus_wr && idx == IDX_PSW) begin
            psw_reg <= merge8(psw_reg, wb_dat_i[7:0], wb_sel_i[0]);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_out <= PORT_RST;
        end else if (byte_wr && byte_addr == ADDR_PORT) begin
            port_out <= new_byte;
        end else if (bus_wr && idx == IDX_PORT) begin
            port_out <= merge8(port_out, wb_dat_i[7:0], wb_sel_i[0]);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_pointer_reg <= DATA_POINTER_RST;
        end else if (exec && data_pointer_op) begin
            data_pointer_reg <= pcu.data_pointer_inc;
        end else if (byte_wr && byte_addr == ADDR_DPL) begin
            data_pointer_reg[7:0] <= new_byte;
        end else if (byte_wr && byte_addr == ADDR_DPH) begin
            data_pointer_reg[15:8] <= new_byte;
        end else if (bus_wr && idx == IDX_DATA_POINTER) begin
            data_pointer_reg <= {merge8(data_pointer_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                         merge8(data_pointer_reg[7:0], wb_dat_i[7:0], wb_sel_i[0])};
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_reg      <= PC_RST;
            taken_reg   <= 1'b0;
            illegal_reg <= 1'b0;
        end else if (exec) begin
            illegal_reg <= illegal;
            taken_reg   <= !illegal && (taken || jump_op);
            if (!illegal) begin
                pc_reg <= pcu.next_pc;
            end
        end else if (bus_wr && idx == IDX_PC) begin
            pc_reg <= {merge8(pc_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                       merge8(pc_reg[7:0], wb_dat_i[7:0], wb_sel_i[0])};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_inc_wrap: assert property (exec && opcode == OP_INC_A && acc_reg == 8'hFF
        |=> acc_reg == 8'h00 && psw_reg == $past(psw_reg))
        else $error("accumulator increment did not wrap to zero");
    chk_inc_dir_len: assert property (exec && opcode == OP_INC_DIR
        |=> pc_reg == $past(pc_reg) + 16'h0002)
        else $error("direct increment did not advance by two");
    chk_inc_port_latch: assert property (exec && opcode == OP_INC_DIR && b1 == ADDR_PORT
        |=> port_out == $past(port_out) + 8'h01)
        else $error("port increment not based on latch");
    chk_data_pointer_step: assert property (exec && opcode == OP_INC_DATA_POINTER
        |=> data_pointer_reg == $past(data_pointer_reg) + 16'h0001 && psw_reg == $past(psw_reg))
        else $error("pointer increment wrong");
    chk_jb_fall: assert property (exec && opcode == OP_JB && !bit_val
        |=> pc_reg == $past(pc_reg) + 16'h0003)
        else $error("bit set branch fall through wrong");
    chk_jbc_keep: assert property (exec && opcode == OP_JBC && !bit_val |-> !byte_wr)
        else $error("cleared bit was rewritten");
    chk_jbc_latch: assert property (exec && opcode == OP_JBC && byte_addr == ADDR_PORT
        |-> cur_byte == port_out)
        else $error("set-and-clear read the pins");
    chk_jc_target: assert property (exec && opcode == OP_JC && psw_reg[CARRY_BIT]
        |=> pc_reg == $past(pc_reg) + 16'h0002
            + {{8{$past(instr_reg[15])}}, $past(instr_reg[15:8])})
        else $error("carry branch target wrong");
    chk_jmp_sum: assert property (exec && opcode == OP_JMP_IND
        |=> pc_reg == $past(data_pointer_reg) + {8'h00, $past(acc_reg)} && data_pointer_reg == $past(data_pointer_reg))
        else $error("indirect jump target wrong");
    chk_jnb_fall: assert property (exec && opcode == OP_JNB && bit_val
        |=> pc_reg == $past(pc_reg) + 16'h0003)
        else $error("bit clear branch fall through wrong");
    chk_exec_once: assert property (go |=> exec ##1 !exec)
        else $error("execution did not last one cycle");
    cov_jbc_taken: cover property (exec && opcode == OP_JBC && bit_val);
    cov_jc_back:   cover property (exec && opcode == OP_JC && taken && b1[7]);
    cov_jmp_carry: cover property (exec && opcode == OP_JMP_IND && (data_pointer_reg[7:0] + acc_reg) > 9'h0FF);
    cov_inc_port:  cover property (exec && inc_byte && byte_addr == ADDR_PORT);
endmodule : inc_branch_exec

/* File: tb/tb_top.sv */
// self-checking bench for the increment and branch execution block
// assumes the block answers classic wishbone requests and runs on one clock
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import core_exec_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and state
    // ----------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0]  wb_adr_i = 6'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rdata;
    logic        wb_ack_o;
    logic [7:0]  port_pins_in = 8'h00, port_out, a, p, m, v, r, op, tgt;
    logic [15:0] pc, d;
    logic [2:0]  b;
    logic        t;
    int          seed = 90263, err_count = 0, comparisons = 0, cycles = 0;
    inc_branch_exec dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .port_pins_in(port_pins_in), .port_out(port_out));
    always #12.5 clk_sys = ~clk_sys;
    // ----------------------------------------------------------------
    // bus tasks and expectations
    // ----------------------------------------------------------------
    task automatic results;
        $display("checks %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            results();
        end
    end
    task automatic wb_io(input logic we, input logic [3:0] idx, input logic [31:0] wd);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_io
    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        wb_io(1'b1, idx, wd);
    endtask : wr
    task automatic chk_reg(input logic [3:0] idx, input logic [31:0] e);
        wb_io(1'b0, idx, 32'h0000_0000);
        `CHK(rdata, e)
    endtask : chk_reg
    task automatic set_ram(input logic [7:0] ad, input logic [7:0] val);
        wr(IDX_RAM_ADDR, {24'h00_0000, ad});
        wr(IDX_RAM_DATA, {24'h00_0000, val});
    endtask : set_ram
    task automatic exec(input logic [23:0] ins);
        wr(IDX_INSTR, {8'h00, ins});
        wr(IDX_CTRL, 32'h0000_0001);
    endtask : exec
    function automatic logic [31:0] exp_pc(input logic [15:0] q, input logic [1:0] len,
                                           input logic [7:0] rel, input logic tk);
        return {16'h0000, q + {14'h0000, len} + (tk ? {{8{rel[7]}}, rel} : 16'h0000)};
    endfunction : exp_pc
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        chk_reg(IDX_PORT, 32'h0000_00FF);
        chk_reg(4'hF, 32'h0000_0000);
        for (int k = 0; k < 6; k++) begin
            a = (k == 0) ? 8'hFF : 8'($random(seed));
            p = 8'($random(seed));
            pc = 16'($random(seed));
            wr(IDX_ACC, {24'h00_0000, a});
            wr(IDX_PSW, {24'h00_0000, p});
            wr(IDX_PC, {16'h0000, pc});
            exec({16'h0000, OP_INC_A});
            chk_reg(IDX_ACC, {24'h00_0000, a + 8'h01});
            chk_reg(IDX_PSW, {24'h00_0000, p});
            chk_reg(IDX_PC, exp_pc(pc, LEN_ONE, 8'h00, 1'b0));
        end
        for (int k = 0; k < 8; k++) begin
            m = {4'h3, 4'($random(seed))};
            v = (k < 4) ? 8'hFF : 8'($random(seed));
            b = 3'($random(seed));
            op = (k % 4 == 0) ? OP_INC_DIR : (k % 4 == 1) ? OP_INC_IND0 :
                 (k % 4 == 2) ? OP_INC_IND1 : {OP_INC_REG, b};
            tgt = (k % 4 == 3) ? {5'h00, b} : m;
            set_ram(8'h00, m);
            set_ram(8'h01, m);
            set_ram(tgt, v);
            wr(IDX_PC, 32'h0000_0100);
            exec({8'h00, m, op});
            wr(IDX_RAM_ADDR, {24'h00_0000, tgt});
            chk_reg(IDX_RAM_DATA, {24'h00_0000, v + 8'h01});
            chk_reg(IDX_PC, (k % 4 == 0) ? 32'h0000_0102 : 32'h0000_0101);
        end
        wr(IDX_PORT, 32'h0000_005D);
        port_pins_in <= 8'hA0;
        exec({8'h00, ADDR_PORT, OP_INC_DIR});
        chk_reg(IDX_PORT, 32'h0000_005E);
        `CHK(port_out, 8'h5E)
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 16'h12FF : (k == 1) ? 16'hFFFF : 16'($random(seed));
            p = 8'($random(seed));
            wr(IDX_DATA_POINTER, {16'h0000, d});
            wr(IDX_PSW, {24'h00_0000, p});
            exec({16'h0000, OP_INC_DATA_POINTER});
            chk_reg(IDX_DATA_POINTER, {16'h0000, d + 16'h0001});
            chk_reg(IDX_PSW, {24'h00_0000, p});
        end
        for (int k = 0; k < 24; k++) begin
            a = 8'($random(seed));
            p = 8'($random(seed));
            b = 3'($random(seed));
            pc = (k < 4) ? 16'hFFFE : 16'($random(seed));
            r = (k < 4) ? {k[0], 7'h7F ^ {7{k[0]}}} : 8'($random(seed));
            op = (k % 4 == 0) ? OP_JB : (k % 4 == 1) ? OP_JNB : (k % 4 == 2) ? OP_JBC : OP_JC;
            t = (op == OP_JC) ? p[CARRY_BIT] : (op == OP_JNB) ? ~a[b] : a[b];
            wr(IDX_ACC, {24'h00_0000, a});
            wr(IDX_PSW, {24'h00_0000, p});
            wr(IDX_PC, {16'h0000, pc});
            exec((op == OP_JC) ? {8'h00, r, op} : {r, ADDR_ACC | {5'h00, b}, op});
            chk_reg(IDX_PC, exp_pc(pc, (op == OP_JC) ? LEN_TWO : LEN_THREE, r, t));
            chk_reg(IDX_ACC, {24'h00_0000, (op == OP_JBC && t) ? a & ~(8'h01 << b) : a});
            chk_reg(IDX_PSW, {24'h00_0000, p});
            chk_reg(IDX_STATUS, {29'h0000_0000, 1'b0, t, 1'b0});
        end
        wr(IDX_PORT, 32'h0000_0004);
        port_pins_in <= 8'h00;
        wr(IDX_PC, 32'h0000_0200);
        exec({8'hF0, ADDR_PORT | 8'h02, OP_JBC});
        chk_reg(IDX_PC, 32'h0000_01F3);
        `CHK(port_out, 8'h00)
        for (int k = 0; k < 4; k++) begin
            a = (k == 0) ? 8'hFF : 8'($random(seed));
            d = (k == 0) ? 16'hFFFF : 16'($random(seed));
            wr(IDX_ACC, {24'h00_0000, a});
            wr(IDX_DATA_POINTER, {16'h0000, d});
            exec({16'h0000, OP_JMP_IND});
            chk_reg(IDX_PC, {16'h0000, d + {8'h00, a}});
            chk_reg(IDX_DATA_POINTER, {16'h0000, d});
            chk_reg(IDX_ACC, {24'h00_0000, a});
        end
        set_ram(8'h2C, 8'h02);
        wr(IDX_PC, 32'h0000_0300);
        exec({8'h10, 8'h61, OP_JB});
        chk_reg(IDX_PC, 32'h0000_0313);
        port_pins_in <= 8'h20;
        wr(IDX_PC, 32'h0000_0400);
        exec({8'h08, ADDR_PORT | 8'h05, OP_JB});
        chk_reg(IDX_PC, 32'h0000_040B);
        wr(IDX_PC, 32'h0000_0500);
        exec({16'h0000, 8'hA5});
        chk_reg(IDX_PC, 32'h0000_0500);
        chk_reg(IDX_STATUS, 32'h0000_0004);
        results();
    end
endmodule : tb_top
